// file: design/sadc_pkg.sv
// Shared constants and state types for the serial converter link.
// Assumes both ends run on one 10 MHz clock named i_mclk.
package sadc_pkg;
   // Widths of the result word and of the channel address.
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 4;
   // Depth of the result FIFO inside the controller.
   localparam int unsigned FIFO_DEPTH = 16;
   // Conversion length in conversion clock cycles.
   localparam logic [5:0] CONV_CYC = 6'h24;
   // Clock cycles that a low select must persist to be taken.
   localparam logic [1:0] RECOG_CYC = 2'h2;
   // Shift clocks per transfer, and how many carry address bits.
   localparam logic [3:0] BIT_CNT = 4'h8;
   localparam logic [3:0] ADDR_BITS = 4'h4;
   // Highest external channel code and the self-test code.
   localparam logic [3:0] CH_LAST_EXT = 4'hA;
   localparam logic [3:0] CH_SELFTEST = 4'hB;
   // Mid-scale code of the self-test source, code of reserved inputs.
   localparam logic [7:0] SELFTEST_CODE = 8'h80;
   localparam logic [7:0] RESERVED_CODE = 8'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   // Controller timing: half shift period, select lead, wait.
   localparam logic [3:0] IO_HALF_CYC = 4'h8;
   localparam logic [4:0] CS_LEAD_CYC = 5'h10;
   localparam logic [6:0] CONV_WAIT_CYC = 7'(CONV_CYC) + 7'h0C;
   // Device states.
   typedef enum logic [2:0] {
      DS_IDLE = 3'b001,
      DS_RECOG = 3'b010,
      DS_ACT = 3'b100
   } sadc_dev_e;
   // Controller states.
   typedef enum logic [3:0] {
      HS_IDLE = 4'b0001,
      HS_LEAD = 4'b0010,
      HS_SHIFT = 4'b0100,
      HS_WAIT = 4'b1000
   } sadc_host_e;
endpackage

// file: design/sadc_if.sv
// Serial link between the converter and its controller.
// Assumes the data line is pulled low whenever the device floats it.
interface sadc_if;
   logic cs_b;      // Chip select, low active.
   logic io_clk;    // Shift clock made by the controller.
   logic addr;      // Channel address bit.
   logic dout;      // Result bit from the device.
   logic dout_oe_b; // Low while the device drives the data line.
   logic data_line; // Resolved level seen by the controller.
   // A floating line reads low here; no high impedance in design code.
   assign data_line = dout & ~dout_oe_b;
   modport dev (input cs_b, input io_clk, input addr, output dout, output dout_oe_b);
   modport host (output cs_b, output io_clk, output addr, input data_line);
endinterface

// file: design/sadc_fifo.sv
// Result FIFO with a registered head word.
// Assumes a power-of-two depth so pointers wrap by themselves.
module sadc_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 16
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Filling side.
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   // Draining side.
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int unsigned PW = $clog2(D);
   localparam int unsigned CW = $clog2(D + 1);
   logic [W-1:0] mem_ff [D];
   logic [W-1:0] nxt_mem [D];
   logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic ov_ff, nxt_ov;
   logic [W-1:0] od_ff, nxt_od;
   logic push, pop;

   // The head register gives one extra word of room beyond D.
   assign o_in_ready = (cnt_ff != CW'(D));
   assign o_out_valid = ov_ff;
   assign o_out_data = od_ff;

   // Next state: write at the tail, move the oldest word to the head.
   always_comb
   begin
      nxt_mem = mem_ff;
      nxt_wp = wp_ff;
      nxt_rp = rp_ff;
      nxt_ov = ov_ff;
      nxt_od = od_ff;
      push = i_in_valid && o_in_ready;
      pop = (cnt_ff != '0) && (!ov_ff || i_out_ready);
      if (push)
      begin
         nxt_mem[wp_ff] = i_in_data;
         nxt_wp = wp_ff + 1'b1;
      end
      if (pop)
      begin
         nxt_od = mem_ff[rp_ff];
         nxt_ov = 1'b1;
         nxt_rp = rp_ff + 1'b1;
      end
      else if (ov_ff && i_out_ready)
      begin
         nxt_ov = 1'b0;
      end
      nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
   end

   // Registers only.
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         for (int i = 0; i < int'(D); i++)
         begin
            mem_ff[i] <= '0;
         end
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         ov_ff <= 1'b0;
         od_ff <= '0;
      end
      else
      begin
         mem_ff <= nxt_mem;
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         ov_ff <= nxt_ov;
         od_ff <= nxt_od;
      end
   end
endmodule

// file: design/sadc_dev.sv
// Converter end: select recognition, address and result shifting,
// sample and hold timing and the 36-cycle conversion sequencer.
// Assumes i_mclk is the conversion clock; link pins are asynchronous.
// Notes on behaviour
// RL1: Select high: output floated, shift clock ignored.
// RL2: Low select taken after conversion clock delay.
// RL3: On recognition, previous result MSB appears unclocked.
// RL4: Address MSB first on first four rising edges.
// RL5: First four falling edges shift result bits 2-5.
// RL6: Sampling starts after fourth falling edge.
// RL7: Next three falling edges shift bits 6-8.
// RL8: Eighth falling edge holds; convert 36 cycles.
// RL9: Controller waits 36 cycles or raises select.
// RL10: Select may stay low; clock must be clean.
// RL11: Recognised select fall resets, aborts conversion.
// RL12: Early new sequence restarts conversion, old result.
// RL13: Conversion and shift clocks fully independent.
// RL14: Eleven inputs or self-test, any order.
// RL15: Common clock: recognition clocks shift nothing.
// RL16: Common clock converts while select is high.
// RL17: Common clock: controller raises select after tenth.
// RL18: Clock held high keeps sampling until fall.
// RL19: Code 1011 converts mid-scale self-test source.
// RL20: Over-range clamps to all ones or zeros.
// RL21: Completion loads result into output shifter; here skipped while a transfer is mid-shift (bc_ff nonzero).
// RL22: Codes 1100-1111 reserved, converted as zero.
module sadc_dev
   import sadc_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Link to the controller.
   sadc_if.dev link,
   // Converter core side.
   input wire logic [DATA_W-1:0] i_code,
   output logic [ADDR_W-1:0] o_chan,
   output logic o_sampling,
   output logic o_busy,
   output logic o_done,
   output logic [DATA_W-1:0] o_result
);
   // Synchroniser stages for the three link inputs.
   logic cs_s1_ff, cs_s2_ff;
   logic io_s1_ff, io_s2_ff, io_prev_ff;
   logic ad_s1_ff, ad_s2_ff;
   // Sequencer state.
   sadc_dev_e st_ff, nxt_st;
   logic [1:0] rc_ff, nxt_rc;           // Recognition counter.
   logic [3:0] bc_ff, nxt_bc;           // Shift clocks seen.
   logic [ADDR_W-1:0] ash_ff, nxt_ash;  // Address shifter.
   logic [ADDR_W-1:0] chan_ff, nxt_chan;
   logic [DATA_W-1:0] sr_ff, nxt_sr;    // Output shifter.
   logic oe_b_ff, nxt_oe_b;
   logic samp_ff, nxt_samp;
   // Conversion state.
   logic busy_ff, nxt_busy;
   logic [5:0] cc_ff, nxt_cc;
   logic [DATA_W-1:0] hold_ff, nxt_hold; // Held input code.
   logic [DATA_W-1:0] res_ff, nxt_res;   // Last finished result.
   logic done_ff, nxt_done;
   logic io_rise, io_fall;

   // Maps the selected channel onto the code the core will resolve.
   // The core already clamps over-range inputs to full or zero scale.
   function automatic logic [DATA_W-1:0] chan_code(input logic [ADDR_W-1:0] ch,
                                                   input logic [DATA_W-1:0] code);
      if (ch <= CH_LAST_EXT)
         chan_code = code; // RL14 RL20
      else if (ch == CH_SELFTEST)
         chan_code = SELFTEST_CODE; // RL19
      else
         chan_code = RESERVED_CODE; // RL22
   endfunction

   // Link pins pass two flops before any logic looks at them.
   // The shift clock is never used as a clock, so no phase relation
   // between it and i_mclk is needed.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         io_s1_ff <= 1'b0;
         io_s2_ff <= 1'b0;
         io_prev_ff <= 1'b0;
         ad_s1_ff <= 1'b0;
         ad_s2_ff <= 1'b0;
      end
      else
      begin
         cs_s1_ff <= link.cs_b;
         cs_s2_ff <= cs_s1_ff;
         io_s1_ff <= link.io_clk; // RL13
         io_s2_ff <= io_s1_ff;
         io_prev_ff <= io_s2_ff;
         ad_s1_ff <= link.addr;
         ad_s2_ff <= ad_s1_ff;
      end
   end

   // Edges of the shift clock, found on the synchronised copy.
   assign io_rise = io_s2_ff && !io_prev_ff;
   assign io_fall = !io_s2_ff && io_prev_ff;

   // Next values of the sequencer and the converter.
   always_comb
   begin
      nxt_st = st_ff;
      nxt_rc = rc_ff;
      nxt_bc = bc_ff;
      nxt_ash = ash_ff;
      nxt_chan = chan_ff;
      nxt_sr = sr_ff;
      nxt_oe_b = oe_b_ff;
      nxt_samp = samp_ff;
      nxt_busy = busy_ff;
      nxt_cc = cc_ff;
      nxt_hold = hold_ff;
      nxt_res = res_ff;
      nxt_done = 1'b0;
      // The conversion clock runs whatever the select does.
      if (busy_ff)
      begin
         if (cc_ff == CONV_CYC - 6'h01)
         begin
            nxt_busy = 1'b0; // RL8
            nxt_res = hold_ff;
            nxt_done = 1'b1;
            // Only reload the shifter when no transfer is under way.
            if (st_ff != DS_ACT || bc_ff == 4'h0)
            begin
               nxt_sr = hold_ff; // RL21
            end
         end
         else
         begin
            nxt_cc = cc_ff + 6'h01; // RL16
         end
      end
      case (st_ff)
         DS_IDLE:
         begin
            // Output floated, clock and address ignored.
            nxt_oe_b = 1'b1; // RL1
            nxt_rc = 2'h0;
            if (!cs_s2_ff)
            begin
               nxt_st = DS_RECOG;
            end
         end
         DS_RECOG:
         begin
            // Shift clocks here are swallowed; with a common clock these
            // are the two recognition cycles.
            if (cs_s2_ff)
            begin
               nxt_st = DS_IDLE; // RL2
            end
            else if (rc_ff == RECOG_CYC - 2'h1)
            begin
               // A taken fall resets the sequence and kills a conversion.
               nxt_st = DS_ACT; // RL2 RL15
               nxt_busy = 1'b0; // RL11
               nxt_done = 1'b0;
               nxt_sr = res_ff; // RL3
               nxt_oe_b = 1'b0; // RL3
               nxt_bc = 4'h0;
               nxt_samp = 1'b0;
            end
            else
            begin
               nxt_rc = rc_ff + 2'h1;
            end
         end
         DS_ACT:
         begin
            if (io_rise && !cs_s2_ff && bc_ff < ADDR_BITS)
            begin
               nxt_ash = {ash_ff[ADDR_W-2:0], ad_s2_ff}; // RL4
            end
            // Both pins pass the same two flops, so a fall that shows up
            // together with the select rise was made while select was low.
            // Dropping it would lose the eighth fall and never convert.
            if (io_fall)
            begin
               nxt_bc = bc_ff + 4'h1;
               nxt_sr = {sr_ff[DATA_W-2:0], 1'b0}; // RL5 RL7
               if (bc_ff == ADDR_BITS - 4'h1)
               begin
                  nxt_chan = ash_ff; // RL14
                  nxt_samp = 1'b1; // RL6
               end
               if (bc_ff == BIT_CNT - 4'h1)
               begin
                  // Hold is taken on this fall however long the
                  // clock stood high, which serves strobed sampling.
                  nxt_samp = 1'b0; // RL18
                  nxt_hold = chan_code(chan_ff, i_code); // RL8
                  nxt_busy = 1'b1; // RL12
                  nxt_cc = 6'h00;
                  nxt_done = 1'b0;
                  nxt_bc = 4'h0; // RL10
                  // A restart keeps the last finished result.
                  nxt_sr = res_ff; // RL12
               end
            end
            if (cs_s2_ff)
            begin
               // A conversion already started keeps running.
               nxt_st = DS_IDLE; // RL1
               nxt_oe_b = 1'b1;
               nxt_samp = 1'b0;
            end
         end
         default:
         begin
            nxt_st = DS_IDLE;
            nxt_oe_b = 1'b1;
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_ff <= DS_IDLE;
         rc_ff <= 2'h0;
         bc_ff <= 4'h0;
         ash_ff <= '0;
         chan_ff <= '0;
         sr_ff <= RESULT_RST;
         oe_b_ff <= 1'b1;
         samp_ff <= 1'b0;
         busy_ff <= 1'b0;
         cc_ff <= 6'h00;
         hold_ff <= RESULT_RST;
         res_ff <= RESULT_RST;
         done_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         rc_ff <= nxt_rc;
         bc_ff <= nxt_bc;
         ash_ff <= nxt_ash;
         chan_ff <= nxt_chan;
         sr_ff <= nxt_sr;
         oe_b_ff <= nxt_oe_b;
         samp_ff <= nxt_samp;
         busy_ff <= nxt_busy;
         cc_ff <= nxt_cc;
         hold_ff <= nxt_hold;
         res_ff <= nxt_res;
         done_ff <= nxt_done;
      end
   end

   // Every output is a flop.
   assign link.dout = sr_ff[DATA_W-1];
   assign link.dout_oe_b = oe_b_ff;
   assign o_chan = chan_ff;
   assign o_sampling = samp_ff;
   assign o_busy = busy_ff;
   assign o_done = done_ff;
   assign o_result = res_ff;
endmodule

// file: design/sadc_host.sv
// Controller end: runs one select-low transfer per request, sends the
// channel, collects the previous result and queues it in a FIFO.
// Assumes the device shares i_mclk or runs at a similar rate.
module sadc_host
   import sadc_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Link to the device.
   sadc_if.host link,
   // Request side.
   input wire logic i_go,
   input wire logic [ADDR_W-1:0] i_chan,
   output logic o_busy,
   // Result stream.
   output logic o_valid,
   output logic [DATA_W-1:0] o_data,
   input wire logic i_ready
);
   logic d_s1_ff, d_s2_ff; // Data line synchroniser.
   sadc_host_e st_ff, nxt_st;
   logic [6:0] cnt_ff, nxt_cnt;
   logic [3:0] bc_ff, nxt_bc;
   logic [ADDR_W-1:0] csh_ff, nxt_csh;
   logic [DATA_W-1:0] rx_ff, nxt_rx;
   logic cs_b_ff, nxt_cs_b, io_ff, nxt_io, ad_ff, nxt_ad;
   logic push_ff, nxt_push, busy_ff, nxt_busy;
   logic fifo_rdy;

   // The result FIFO; a full FIFO stops new transfers.
   sadc_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .i_clk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_in_valid(push_ff),
      .i_in_data(rx_ff),
      .o_in_ready(fifo_rdy),
      .o_out_valid(o_valid),
      .o_out_data(o_data),
      .i_out_ready(i_ready)
   );

   // Next values of the transfer sequencer.
   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff + 7'h01;
      nxt_bc = bc_ff;
      nxt_csh = csh_ff;
      nxt_rx = rx_ff;
      nxt_cs_b = cs_b_ff;
      nxt_io = io_ff;
      nxt_ad = ad_ff;
      nxt_push = 1'b0;
      nxt_busy = busy_ff;
      case (st_ff)
         HS_IDLE:
         begin
            nxt_cnt = 7'h00;
            if (i_go && fifo_rdy)
            begin
               // Address MSB first, set before the first rising edge.
               nxt_st = HS_LEAD;
               nxt_cs_b = 1'b0;
               nxt_csh = i_chan; // RL4
               nxt_ad = i_chan[ADDR_W-1];
               nxt_bc = 4'h0;
               nxt_busy = 1'b1;
            end
         end
         HS_LEAD:
         begin
            // Leave time for the device to recognise the select.
            if (cnt_ff == 7'(CS_LEAD_CYC) - 7'h01)
            begin
               nxt_st = HS_SHIFT;
               nxt_io = 1'b1;
               nxt_cnt = 7'h00;
            end
         end
         HS_SHIFT:
         begin
            if (cnt_ff == 7'(IO_HALF_CYC) - 7'h01)
            begin
               nxt_cnt = 7'h00;
               if (io_ff)
               begin
                  // Sample the bit just before driving the fall.
                  nxt_io = 1'b0;
                  nxt_rx = {rx_ff[DATA_W-2:0], d_s2_ff};
                  nxt_csh = {csh_ff[ADDR_W-2:0], 1'b0};
                  nxt_ad = csh_ff[ADDR_W-2];
                  nxt_bc = bc_ff + 4'h1;
                  if (bc_ff == BIT_CNT - 4'h1)
                  begin
                     // Select goes high so the conversion can run.
                     nxt_cs_b = 1'b1; // RL9 RL17
                     nxt_push = 1'b1;
                     nxt_st = HS_WAIT;
                  end
               end
               else
               begin
                  nxt_io = 1'b1; // RL10
               end
            end
         end
         HS_WAIT:
         begin
            // Select stays high for the whole conversion.
            if (cnt_ff == CONV_WAIT_CYC - 7'h01)
            begin
               nxt_st = HS_IDLE; // RL11
               nxt_busy = 1'b0;
            end
         end
         default:
         begin
            nxt_st = HS_IDLE;
            nxt_cs_b = 1'b1;
         end
      endcase
   end

   // Registers, the data line passing two flops first.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         d_s1_ff <= 1'b0;
         d_s2_ff <= 1'b0;
         st_ff <= HS_IDLE;
         cnt_ff <= 7'h00;
         bc_ff <= 4'h0;
         csh_ff <= '0;
         rx_ff <= RESULT_RST;
         cs_b_ff <= 1'b1;
         io_ff <= 1'b0;
         ad_ff <= 1'b0;
         push_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else
      begin
         d_s1_ff <= link.data_line;
         d_s2_ff <= d_s1_ff;
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         bc_ff <= nxt_bc;
         csh_ff <= nxt_csh;
         rx_ff <= nxt_rx;
         cs_b_ff <= nxt_cs_b;
         io_ff <= nxt_io;
         ad_ff <= nxt_ad;
         push_ff <= nxt_push;
         busy_ff <= nxt_busy;
      end
   end

   assign link.cs_b = cs_b_ff;
   assign link.io_clk = io_ff;
   assign link.addr = ad_ff;
   assign o_busy = busy_ff;
endmodule

// file: testbench/sadc_link_assertions.sv
// Checker for the serial link between the controller and the converter.
// Assumes one clock domain, i_mclk, with the asynchronous low reset i_rst_b.
module sadc_link_chk
   import sadc_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Link wires.
   input wire logic cs_b,
   input wire logic io_clk,
   input wire logic addr,
   input wire logic dout,
   input wire logic dout_oe_b,
   input wire logic data_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic io_q_ff; // Shift clock level one cycle ago.
   logic [3:0] falls_ff; // Shift clock falls seen in this frame.
   logic [3:0] nxt_falls; // Next fall count.

   // A high select clears the count, so at the eighth fall it still shows seven.
   always_comb
   begin
      nxt_falls = cs_b ? 4'h0 : falls_ff + {3'h0, io_q_ff & ~io_clk};
   end

   // Registers of the helper count.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         io_q_ff <= 1'b0;
         falls_ff <= 4'h0;
      end
      else
      begin
         io_q_ff <= io_clk;
         falls_ff <= nxt_falls;
      end
   end

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   // The line stays floated through recognition, then the device drives it.
   sequence s_recog;
      dout_oe_b[*4] ##[1:4] !dout_oe_b;
   endsequence

   float_when_high_a: assert property (cs_b[*6] |-> dout_oe_b)
      else $error("data line driven while deselected");
   select_recog_a: assert property ($fell(cs_b) |-> s_recog)
      else $error("select recognised at the wrong time");
   msb_unclocked_a: assert property ($fell(cs_b) |-> (!io_clk)[*8] ##0 !dout_oe_b)
      else $error("first bit not driven before any shift clock");
   addr_stable_a: assert property ($rose(io_clk) |-> $stable(addr))
      else $error("address moved at a rising shift clock");
   dout_hold_a: assert property ($rose(io_clk) && !cs_b |-> $stable(dout)[*8])
      else $error("result bit moved while the shift clock was high");
   eight_clocks_a: assert property ($rose(cs_b) |-> $fell(io_clk) && falls_ff == 4'h7)
      else $error("frame did not end at the eighth fall");
   conv_wait_a: assert property ($rose(cs_b) |-> cs_b throughout (##40 1'b1))
      else $error("select fell again before the conversion ended");
   idle_clock_a: assert property (cs_b |-> !io_clk)
      else $error("shift clock ran outside a frame");
   half_period_a: assert property ($changed(io_clk) |-> ##1 $stable(io_clk)[*2])
      else $error("shift clock phase shorter than three cycles");
endmodule

// file: testbench/tb_serial_adc_control_sequencer.sv
// Bench for the converter link: controller and converter face each other,
// and a second converter is driven by hand to break the controller's rules.
// Assumes the package, interface, FIFO, both ends and the checker come first.
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("BAD %0t got %h want %h", $time, a, e); end end
module tb_serial_adc_control_sequencer
   import sadc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk, i_rst_b, i_go, i_ready, rnd_rdy; // Bench-driven controls.
   logic [3:0] i_chan; // Channel for the next transfer.
   logic [7:0] dcode, code2, prev, exp; // Core codes and expected bytes.
   logic h_busy, o_valid, d_busy, d_done, d2_busy, d2_samp; // Observed flags.
   logic [7:0] o_data, d_res, d2_res; // Observed results.
   logic [3:0] d_chan, d2_chan; // Observed channels.
   logic [7:0] exp_q[$]; // Bytes the result stream still owes.
   int fail_count, checks, cyc, bcnt; // Counters.
   integer seed = 84299; // Fixed seed so the run repeats.
   sadc_if lnk();
   sadc_if lnk2();

   sadc_host sadc_host_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(lnk), .i_go(i_go), .i_chan(i_chan),
      .o_busy(h_busy), .o_valid(o_valid), .o_data(o_data), .i_ready(i_ready));
   sadc_dev sadc_dev_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(lnk), .i_code(dcode), .o_chan(d_chan),
      .o_sampling(), .o_busy(d_busy), .o_done(d_done), .o_result(d_res));
   sadc_dev sadc_dev2_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .link(lnk2), .i_code(code2), .o_chan(d2_chan),
      .o_sampling(d2_samp), .o_busy(d2_busy), .o_done(), .o_result(d2_res));
   sadc_link_chk sadc_link_chk_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .cs_b(lnk.cs_b), .io_clk(lnk.io_clk),
      .addr(lnk.addr), .dout(lnk.dout), .dout_oe_b(lnk.dout_oe_b), .data_line(lnk.data_line));

   // Free-running 10 MHz clock.
   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   // Code the device should produce for a channel and core code.
   function automatic logic [7:0] conv(input logic [3:0] ch, input logic [7:0] c);
      conv = (ch == CH_SELFTEST) ? SELFTEST_CODE : (ch > CH_SELFTEST) ? RESERVED_CODE : c;
   endfunction

   // Prints the verdict and ends the run.
   task automatic stop_test;
      if (fail_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Waits, bounded, for the controller's busy flag to reach a level.
   task automatic wait_busy(input logic v);
      int n;
      for (n = 0; n < 300 && h_busy !== v; n++) @(negedge i_mclk);
      `CHK(h_busy, v)
   endtask

   // One controller transfer; the stream must return the previous result.
   task automatic xfer(input logic [3:0] ch, input logic [7:0] c);
      @(negedge i_mclk);
      i_chan = ch;
      dcode = c;
      i_go = 1'b1;
      wait_busy(1'b1);
      i_go = 1'b0;
      exp_q.push_back(prev);
      prev = conv(ch, c);
      wait_busy(1'b0);
      `CHK(d_chan, ch)
      `CHK(d_res, prev)
   endtask

   // Lets the reader take everything owed; waits one edge so the random driver is off.
   task automatic drain;
      int n;
      @(negedge i_mclk);
      i_ready = 1'b1;
      for (n = 0; n < 200 && exp_q.size() > 0; n++) @(negedge i_mclk);
      `CHK(exp_q.size(), 0)
   endtask

   // Hand-made frame on the second link, timed on its own 800 ns clock.
   task automatic lx(input logic [3:0] ch, input logic sel, output logic [7:0] rd, output logic oe);
      int i;
      oe = 1'b1;
      lnk2.cs_b = ~sel;
      #1000;
      for (i = 0; i < 8; i++)
      begin
         // Past the address bits the line toggles, so nothing leans on a held value.
         lnk2.addr = (i < 4) ? ch[3 - i] : ~lnk2.addr;
         #400 lnk2.io_clk = 1'b1;
         #200 rd[7 - i] = lnk2.data_line;
         oe = oe & lnk2.dout_oe_b;
         `CHK(d2_samp, (i > 3) && sel)
         #200 lnk2.io_clk = 1'b0;
      end
   endtask

   // Random reader stall during the second phase.
   always @(negedge i_mclk)
   begin
      if (rnd_rdy)
         i_ready <= 1'($random(seed));
   end

   // Stream scoreboard, conversion length and the hang limit.
   always @(posedge i_mclk)
   begin
      if (o_valid === 1'b1 && i_ready === 1'b1)
      begin
         exp = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         `CHK(o_data, exp)
      end
      if (d_done === 1'b1)
         `CHK(bcnt, int'(CONV_CYC))
      bcnt = (d_busy === 1'b1) ? bcnt + 1 : 0;
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         stop_test;
      end
   end

   // Main sequence.
   initial
   begin
      logic [7:0] rd;
      logic oe;
      logic [3:0] ch;
      int i;
      i_rst_b = 1'b0;
      i_go = 1'b0;
      i_chan = 4'h0;
      i_ready = 1'b0;
      rnd_rdy = 1'b0;
      dcode = 8'h00;
      code2 = 8'h00;
      prev = RESULT_RST;
      lnk2.cs_b = 1'b1;
      lnk2.io_clk = 1'b0;
      lnk2.addr = 1'b0;
      repeat (3) @(negedge i_mclk);
      i_rst_b = 1'b1;
      // Stalled reader: 17 transfers fill the FIFO, corner channels and codes first.
      for (i = 0; i < 17; i++)
      begin
         ch = (i == 1) ? CH_LAST_EXT : (i == 2) ? CH_SELFTEST : (i == 4) ? 4'hF : 4'($unsigned($random(seed)) % 12);
         xfer((i == 0) ? 4'h0 : ch, (i == 0) ? 8'hFF : (i == 3) ? 8'h00 : 8'($random(seed)));
      end
      // A full FIFO must refuse a new request.
      i_go = 1'b1;
      repeat (20) @(negedge i_mclk);
      `CHK(h_busy, 1'b0)
      i_go = 1'b0;
      drain;
      rnd_rdy = 1'b1;
      for (i = 0; i < 12; i++) xfer(4'($unsigned($random(seed)) % 12), 8'($random(seed)));
      rnd_rdy = 1'b0;
      drain;
      // Second converter: shifting with select high must leave it idle.
      lx(4'h5, 1'b0, rd, oe);
      `CHK(oe, 1'b1)
      `CHK(d2_chan, 4'h0)
      code2 = 8'h96;
      lx(4'h3, 1'b1, rd, oe);
      `CHK(rd, RESULT_RST)
      #5000;
      `CHK(d2_res, 8'h96)
      `CHK(d2_samp, 1'b0)
      `CHK(d2_chan, 4'h3)
      // Select stays low into the next frame.
      code2 = 8'h3C;
      lx(CH_SELFTEST, 1'b1, rd, oe);
      `CHK(rd, 8'h96)
      #5000;
      `CHK(d2_res, SELFTEST_CODE)
      // A recognised select fall in mid-conversion throws the new code away.
      code2 = 8'h11;
      lx(4'h2, 1'b1, rd, oe);
      #1000 lnk2.cs_b = 1'b1;
      #700 lnk2.cs_b = 1'b0;
      #5000;
      `CHK(d2_res, SELFTEST_CODE)
      `CHK(d2_busy, 1'b0)
      `CHK(lnk2.dout_oe_b, 1'b0)
      `CHK(lnk2.data_line, SELFTEST_CODE[7])
      lnk2.cs_b = 1'b1;
      stop_test;
   end
endmodule
